//--- rtl/psu_pmbus_command_handler.sv
// command handler: decodes supply commands, holds operating parameters
// What this block does
// - out-of-range parameter write keeps setting and raises comm fault flag
// - on/off accepts only on and off data values, others are faults
// - main output is on after power up
// - off-then-on restart clears all latched alarms and shutdowns
// - clear-faults clears status and alert of controlling port, ignores lock
// - clear-faults from the port not in control changes nothing
// - persisting faults clear first and then set again
// - lock decodes allow all, lock-only, lock plus on/off
// - reads of supported commands always succeed regardless of lock
// - lock setting can never be stored as user default
// - lock defaults to allow all; writing a valid lock value always accepted
// - restore-all reloads every parameter from fixed factory defaults
// - restore-single reloads one addressed parameter from factory default
// - store-user and restore-user act on exactly one addressed parameter
// - output voltage format byte reads linear mode and fixed exponent
// - output voltage values are 16-bit unsigned mantissa with exponent -9
// - setpoint write changes output within range; storable as user default
// - voltage pin sets setpoint at turn on until a digital write
// - removing input power restores defaults and pin control
// - input start and stop levels are read only
// - over-voltage fault limit defaults to sixty volts and is storable
// - transactions without valid packet error code are errors
`timescale 1ns/1ps
`include "psu_cmd_defines.svh"

module psu_pmbus_command_handler #(
  parameter logic [15:0] IN_START_LEVEL = 16'hF960,
  parameter logic [15:0] IN_STOP_LEVEL = 16'hF92C,
  parameter logic [31:0] MAKER_CODE = 32'h5A5A0001, // arbitrary value
  parameter logic [95:0] MODEL_CODE = 96'h0123456789ABCDEF00000001 // arbitrary value
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input psu_cmd_pkg::cmd_t cmdIn,
  input wire logic controlPort,
  input wire logic acPresent,
  input wire logic vprogEn,
  input wire logic [15:0] vprogLevel,
  input wire logic [7:0] faultLive,
  output psu_cmd_pkg::rsp_t rsp_ff,
  output logic mainOn_ff,
  output logic [15:0] voutTarget_ff,
  output logic [15:0] ovLimit_ff,
  output logic [7:0] status_ff,
  output logic commFault_ff,
  output logic [1:0] alertN_ff,
  output logic [7:0] lock_ff
);

  // ----------------------------------------------------------------
  // decode functions
  // ----------------------------------------------------------------
  function automatic logic [5:0] prmIndex(input logic [7:0] code);
    case (code)
      `CMD_VOUT_SET: prmIndex = 6'h20;
      `CMD_OVF: prmIndex = 6'h21;
      `CMD_OVW: prmIndex = 6'h22;
      `CMD_UVW: prmIndex = 6'h23;
      `CMD_UVF: prmIndex = 6'h24;
      `CMD_OCF: prmIndex = 6'h25;
      `CMD_OCLV: prmIndex = 6'h26;
      `CMD_OCW: prmIndex = 6'h27;
      `CMD_OTF: prmIndex = 6'h28;
      `CMD_OTW: prmIndex = 6'h29;
      `CMD_VINOVW: prmIndex = 6'h2A;
      `CMD_VINUVW: prmIndex = 6'h2B;
      `CMD_IINOCW: prmIndex = 6'h2C;
      `CMD_TTIME: prmIndex = 6'h2D;
      `CMD_OCTRIG: prmIndex = 6'h2E;
      `CMD_OCCAP: prmIndex = 6'h2F;
      `CMD_ASSERT: prmIndex = 6'h30;
      default: prmIndex = 6'h00;
    endcase
  endfunction : prmIndex

  // factory values cannot be written: they live only in this table
  function automatic logic [47:0] prmTable(input logic [4:0] idx);
    case (idx)
      5'd0: prmTable = `PRM_00;
      5'd1: prmTable = `PRM_01;
      5'd2: prmTable = `PRM_02;
      5'd3: prmTable = `PRM_03;
      5'd4: prmTable = `PRM_04;
      5'd5: prmTable = `PRM_05;
      5'd6: prmTable = `PRM_06;
      5'd7: prmTable = `PRM_07;
      5'd8: prmTable = `PRM_08;
      5'd9: prmTable = `PRM_09;
      5'd10: prmTable = `PRM_10;
      5'd11: prmTable = `PRM_11;
      5'd12: prmTable = `PRM_12;
      5'd13: prmTable = `PRM_13;
      5'd14: prmTable = `PRM_14;
      5'd15: prmTable = `PRM_15;
      5'd16: prmTable = `PRM_16;
      default: prmTable = 48'h000000000000;
    endcase
  endfunction : prmTable

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [17:0] pinMeta_ff;
  logic [17:0] pinSync_ff;
  logic acPrev_ff;
  logic acSync;
  logic vprogEnSync;
  logic [15:0] vprogSync;
  logic acFall;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pinMeta_ff <= 18'h00000;
      pinSync_ff <= 18'h00000;
      acPrev_ff <= 1'b0;
    end
    else
    begin
      pinMeta_ff <= {acPresent, vprogEn, vprogLevel};
      pinSync_ff <= pinMeta_ff;
      acPrev_ff <= pinSync_ff[17];
    end
  end

  logic [7:0] faultMeta_ff;
  logic [7:0] faultSync_ff;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      faultMeta_ff <= 8'h00;
      faultSync_ff <= 8'h00;
    end
    else
    begin
      faultMeta_ff <= faultLive;
      faultSync_ff <= faultMeta_ff;
    end
  end

  assign acSync = pinSync_ff[17];
  assign vprogEnSync = pinSync_ff[16];
  assign vprogSync = pinSync_ff[15:0];
  assign acFall = acPrev_ff & ~acSync;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  logic [15:0] param_ff [`NPRM];
  logic [15:0] userDef_ff [`NPRM];
  logic [5:0] hitIdx;
  logic [5:0] argIdx;
  logic [47:0] lim;
  logic take;
  logic lockPass;
  logic doOnOff;
  logic doClear;
  logic doLock;
  logic doRestoreAll;
  logic doRestoreOne;
  logic doStore;
  logic doRestoreUser;
  logic doParam;
  logic errEvt;
  logic rdOk;
  logic [95:0] rdWord;
  logic [3:0] rdBytes;

  assign hitIdx = prmIndex(cmdIn.code);
  assign argIdx = prmIndex(cmdIn.data[7:0]);
  assign lim = prmTable(hitIdx[4:0]);
  assign take = cmdIn.valid & cmdIn.write & cmdIn.pecOk;
  assign lockPass = (lock_ff == `LOCK_NONE) || (cmdIn.code == `CMD_LOCK)
    || (lock_ff == `LOCK_OP && cmdIn.code == `CMD_ON_OFF);

  always_comb
  begin
    doOnOff = 1'b0;
    doClear = 1'b0;
    doLock = 1'b0;
    doRestoreAll = 1'b0;
    doRestoreOne = 1'b0;
    doStore = 1'b0;
    doRestoreUser = 1'b0;
    doParam = 1'b0;
    errEvt = cmdIn.valid & ~cmdIn.pecOk;
    if (take && cmdIn.code == `CMD_CLEAR)
      doClear = (cmdIn.port == controlPort);
    else if (take && !lockPass)
      errEvt = 1'b1;
    else if (take)
    begin
      case (cmdIn.code)
        `CMD_ON_OFF:
        begin
          doOnOff = (cmdIn.data[7:0] == `ON_DATA) || (cmdIn.data[7:0] == `OFF_DATA);
          errEvt = ~doOnOff;
        end
        `CMD_LOCK:
        begin
          doLock = (cmdIn.data[7:0] == `LOCK_NONE) || (cmdIn.data[7:0] == `LOCK_ALL)
            || (cmdIn.data[7:0] == `LOCK_OP);
          errEvt = ~doLock;
        end
        `CMD_RESTORE_ALL: doRestoreAll = 1'b1;
        `CMD_RESTORE_ONE:
        begin
          doRestoreOne = argIdx[5];
          errEvt = ~argIdx[5];
        end
        `CMD_STORE_USER:
        begin
          doStore = argIdx[5];
          errEvt = ~argIdx[5];
        end
        `CMD_RESTORE_USER:
        begin
          doRestoreUser = argIdx[5];
          errEvt = ~argIdx[5];
        end
        default:
        begin
          doParam = hitIdx[5] && cmdIn.data >= lim[31:16] && cmdIn.data <= lim[15:0];
          errEvt = ~doParam;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb
  begin
    rdOk = 1'b1;
    rdBytes = 4'h2;
    rdWord = 96'h0;
    case (cmdIn.code)
      `CMD_ON_OFF:
      begin
        rdBytes = 4'h1;
        rdWord[7:0] = mainOn_ff ? `ON_DATA : `OFF_DATA;
      end
      `CMD_LOCK:
      begin
        rdBytes = 4'h1;
        rdWord[7:0] = lock_ff;
      end
      `CMD_VOUT_FORMAT:
      begin
        rdBytes = 4'h1;
        rdWord[7:0] = `VOUT_FMT_BYTE;
      end
      `CMD_IN_START: rdWord[15:0] = IN_START_LEVEL;
      `CMD_IN_STOP: rdWord[15:0] = IN_STOP_LEVEL;
      `CMD_MAKER:
      begin
        rdBytes = 4'h4;
        rdWord[31:0] = MAKER_CODE;
      end
      `CMD_MODEL:
      begin
        rdBytes = 4'hC;
        rdWord = MODEL_CODE;
      end
      default:
      begin
        rdOk = hitIdx[5];
        rdBytes = hitIdx[5] ? 4'h2 : 4'h0;
        rdWord[15:0] = hitIdx[5] ? param_ff[hitIdx[4:0]] : 16'h0000;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      rsp_ff <= '0;
    else
    begin
      rsp_ff.valid <= cmdIn.valid & ~cmdIn.write;
      rsp_ff.fault <= cmdIn.valid & ~cmdIn.write & (~rdOk | ~cmdIn.pecOk);
      rsp_ff.bytes <= rdBytes;
      rsp_ff.data <= rdWord;
    end
  end

  // ----------------------------------------------------------------
  // output control and write lock
  // ----------------------------------------------------------------
  logic restart;
  logic rdErr;

  assign restart = doOnOff && cmdIn.data[7:0] == `ON_DATA && !mainOn_ff;
  assign rdErr = cmdIn.valid & ~cmdIn.write & cmdIn.pecOk & ~rdOk;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      mainOn_ff <= 1'b1;
    else if (acFall)
      mainOn_ff <= 1'b1;
    else if (doOnOff)
      mainOn_ff <= (cmdIn.data[7:0] == `ON_DATA);
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      lock_ff <= `LOCK_NONE;
    else if (acFall)
      lock_ff <= `LOCK_NONE;
    else if (doLock)
      lock_ff <= cmdIn.data[7:0];
  end

  // ----------------------------------------------------------------
  // parameters and user defaults
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `NPRM; gi++)
    begin : gPrm
      localparam logic [4:0] IDX = 5'(gi);
      localparam logic [47:0] ENTRY = prmTable(IDX);
      always_ff @(posedge ref_clk or negedge arst_n)
      begin
        if (!arst_n)
          param_ff[gi] <= ENTRY[47:32];
        else if (acFall)
          param_ff[gi] <= userDef_ff[gi];
        else if (doRestoreAll || (doRestoreOne && argIdx[4:0] == IDX))
          param_ff[gi] <= ENTRY[47:32];
        else if (doRestoreUser && argIdx[4:0] == IDX)
          param_ff[gi] <= userDef_ff[gi];
        else if (doParam && hitIdx[4:0] == IDX)
          param_ff[gi] <= cmdIn.data;
      end
      always_ff @(posedge ref_clk or negedge arst_n)
      begin
        if (!arst_n)
          userDef_ff[gi] <= ENTRY[47:32];
        else if (doStore && argIdx[4:0] == IDX)
          userDef_ff[gi] <= param_ff[gi];
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      ovLimit_ff <= 16'(`PRM_01 >> 32);
    else
      ovLimit_ff <= param_ff[1];
  end

  // ----------------------------------------------------------------
  // setpoint source: pin until a digital write
  // ----------------------------------------------------------------
  logic digitalSet_ff;
  logic [1:0] upCnt_ff;
  logic [15:0] vprogHeld_ff;
  logic [15:0] vsetParam;

  assign vsetParam = param_ff[`PRM_VSET];

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      digitalSet_ff <= 1'b0;
    else if (acFall)
      digitalSet_ff <= 1'b0;
    else if (doParam && hitIdx[4:0] == `PRM_VSET)
      digitalSet_ff <= 1'b1;
  end

  // capture window spans the synchroniser stages after reset or power loss
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      upCnt_ff <= 2'h3;
    else if (acFall)
      upCnt_ff <= 2'h3;
    else if (upCnt_ff != 2'h0)
      upCnt_ff <= upCnt_ff - 2'h1;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      vprogHeld_ff <= 16'h0000;
    else if (upCnt_ff != 2'h0 || !mainOn_ff)
      vprogHeld_ff <= vprogSync;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      voutTarget_ff <= 16'(`PRM_00 >> 32);
    else if (!digitalSet_ff && vprogEnSync)
      voutTarget_ff <= vprogHeld_ff;
    else
      voutTarget_ff <= vsetParam;
  end

  // ----------------------------------------------------------------
  // status, comm fault and alerts
  // ----------------------------------------------------------------
  logic [7:0] newFault;

  assign newFault = faultSync_ff & ~status_ff;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      status_ff <= `STATUS_RST;
    else if (doClear || restart)
      status_ff <= `STATUS_RST;
    else
      status_ff <= status_ff | faultSync_ff;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      commFault_ff <= 1'b0;
    else if (errEvt || rdErr)
      commFault_ff <= 1'b1;
    else if (doClear || restart)
      commFault_ff <= 1'b0;
  end

  generate
    for (gi = 0; gi < 2; gi++)
    begin : gAlert
      always_ff @(posedge ref_clk or negedge arst_n)
      begin
        if (!arst_n)
          alertN_ff[gi] <= 1'b1;
        // clear wins: a persisting fault shows as new again next cycle
        else if ((doClear && cmdIn.port == 1'(gi)) || restart)
          alertN_ff[gi] <= 1'b1;
        else if ((errEvt || rdErr || |newFault) && controlPort == 1'(gi))
          alertN_ff[gi] <= 1'b0;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  range_reject_a: assert property (
    take && lockPass && cmdIn.code == `CMD_VOUT_SET && cmdIn.data > 16'h7400
    |=> $stable(vsetParam) && commFault_ff)
    else $error("out of range setpoint was taken");
  onoff_value_a: assert property (
    take && lockPass && cmdIn.code == `CMD_ON_OFF && cmdIn.data[7:0] == 8'h01
    |=> $stable(mainOn_ff) && commFault_ff)
    else $error("bad on/off data was taken");
  ac_default_a: assert property (acFall |=> mainOn_ff && lock_ff == 8'h00
    ##1 voutTarget_ff == vsetParam || vprogEnSync)
    else $error("power loss did not restore defaults");
  restart_clear_a: assert property (restart |=> status_ff == 8'h00
    && !commFault_ff && alertN_ff == 2'b11)
    else $error("restart left alarms set");
  clear_other_a: assert property (
    take && cmdIn.code == `CMD_CLEAR && cmdIn.port != controlPort && commFault_ff
    |=> commFault_ff)
    else $error("clear from idle port acted");
  clear_refire_a: assert property (
    doClear && faultSync_ff[0] ##1 faultSync_ff[0] && !doClear && !restart
    |-> status_ff[0] == 1'b0 ##1 status_ff[0])
    else $error("persisting fault did not come back");
  lock_block_a: assert property (
    take && lock_ff == 8'h80 && cmdIn.code == `CMD_ON_OFF |=> $stable(mainOn_ff)
    && commFault_ff)
    else $error("locked write was taken");
  read_lock_a: assert property (
    cmdIn.valid && !cmdIn.write && cmdIn.pecOk && cmdIn.code == `CMD_VOUT_SET
    |=> rsp_ff.valid && !rsp_ff.fault && rsp_ff.data[15:0] == $past(vsetParam))
    else $error("read refused");
  store_lock_a: assert property (
    take && lockPass && cmdIn.code == `CMD_STORE_USER && cmdIn.data[7:0] == 8'h10
    |=> commFault_ff)
    else $error("lock store not refused");
  vout_fmt_a: assert property (
    cmdIn.valid && !cmdIn.write && cmdIn.code == `CMD_VOUT_FORMAT
    |=> rsp_ff.data[7:0] == 8'h17 && rsp_ff.bytes == 4'h1)
    else $error("format byte wrong");
  digital_wins_a: assert property (
    digitalSet_ff |=> voutTarget_ff == $past(vsetParam))
    else $error("pin overrode digital setpoint");
  alert_set_a: assert property (
    (errEvt || rdErr) && controlPort == 1'b0
    |=> !alertN_ff[0] ##1 (!alertN_ff[0] || $past(doClear || restart)))
    else $error("alert not raised on comm fault");

  restart_c: cover property (doOnOff && cmdIn.data[7:0] == `OFF_DATA ##[1:60] restart);
  clear_c: cover property (commFault_ff ##1 doClear);
  store_c: cover property (doStore ##[1:20] doRestoreUser);

endmodule : psu_pmbus_command_handler

//--- rtl/psu_cmd_defines.svh
// constants of the power supply command handler
`ifndef PSU_CMD_DEFINES_SVH
`define PSU_CMD_DEFINES_SVH

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define CMD_ON_OFF 8'h01
`define CMD_CLEAR 8'h03
`define CMD_LOCK 8'h10
`define CMD_RESTORE_ALL 8'h12
`define CMD_RESTORE_ONE 8'h14
`define CMD_STORE_USER 8'h17
`define CMD_RESTORE_USER 8'h18
`define CMD_VOUT_FORMAT 8'h20
`define CMD_VOUT_SET 8'h21
`define CMD_IN_START 8'h35
`define CMD_IN_STOP 8'h36
`define CMD_OVF 8'h40
`define CMD_OVW 8'h42
`define CMD_UVW 8'h43
`define CMD_UVF 8'h44
`define CMD_OCF 8'h46
`define CMD_OCLV 8'h48
`define CMD_OCW 8'h4A
`define CMD_OTF 8'h4F
`define CMD_OTW 8'h51
`define CMD_VINOVW 8'h57
`define CMD_VINUVW 8'h58
`define CMD_IINOCW 8'h5D
`define CMD_MAKER 8'h99
`define CMD_MODEL 8'h9A
`define CMD_TTIME 8'hF4
`define CMD_OCTRIG 8'hF5
`define CMD_OCCAP 8'hF6
`define CMD_ASSERT 8'hF7

// ----------------------------------------------------------------
// data values and reset values
// ----------------------------------------------------------------
`define ON_DATA 8'h80
`define OFF_DATA 8'h00
`define LOCK_NONE 8'h00
`define LOCK_ALL 8'h80
`define LOCK_OP 8'h40
`define VOUT_FMT_BYTE 8'h17
`define STATUS_RST 8'h00
`define NPRM 17
`define PRM_VSET 5'h00

// ----------------------------------------------------------------
// parameters as {factory default, low limit, high limit}
// ----------------------------------------------------------------
`define PRM_00 {16'h6E00, 16'h5000, 16'h7400}
`define PRM_01 {16'h7800, 16'h5400, 16'h7E00}
`define PRM_02 {16'h7600, 16'h5400, 16'h7E00}
`define PRM_03 {16'h6800, 16'h4600, 16'h7400}
`define PRM_04 {16'h4C00, 16'h4600, 16'h7400}
`define PRM_05 {16'hF8B0, 16'hF814, 16'hF8B0}
`define PRM_06 {16'hF846, 16'hF80A, 16'hF846}
`define PRM_07 {16'hF8AD, 16'hF802, 16'hF8B4}
`define PRM_08 {16'hF8C8, 16'hF88C, 16'hF92C}
`define PRM_09 {16'hF8BE, 16'hF88C, 16'hF92C}
`define PRM_10 {16'hFA4E, 16'hF972, 16'hFA62}
`define PRM_11 {16'hF954, 16'hF88C, 16'hFA12}
`define PRM_12 {16'hF83C, 16'hF814, 16'hF850}
`define PRM_13 {16'hF806, 16'hF802, 16'hF92C}
`define PRM_14 {16'h0000, 16'h0000, 16'h0001}
`define PRM_15 {16'hF8C8, 16'hF800, 16'hF8DC}
`define PRM_16 {16'hF9F4, 16'hF8C8, 16'hFA58}

`endif

//--- rtl/psu_cmd_pkg.sv
// types of the power supply command handler
package psu_cmd_pkg;

  typedef struct packed {
    logic valid;
    logic write;
    logic port;
    logic pecOk;
    logic [7:0] code;
    logic [15:0] data;
  } cmd_t;

  typedef struct packed {
    logic valid;
    logic fault;
    logic [3:0] bytes;
    logic [95:0] data;
  } rsp_t;

endpackage : psu_cmd_pkg

//--- testbench/host_ctrl_model.sv
// host controller model issuing supply commands
`timescale 1ns/1ps
`include "psu_cmd_defines.svh"

module host_ctrl_model #(
  parameter int OFF_WAIT = 40
) (
  input wire logic ref_clk,
  input psu_cmd_pkg::rsp_t rsp_ff,
  output psu_cmd_pkg::cmd_t cmdOut
);
  psu_cmd_pkg::rsp_t lastRsp;
  initial cmdOut = '0;
  // answers stand one cycle, so they are caught here
  always @(posedge ref_clk)
  begin
    if (rsp_ff.valid)
      lastRsp <= rsp_ff;
  end
  task automatic send(input logic w, input logic p, input logic pec, input logic [7:0] code,
    input logic [15:0] d);
    @(posedge ref_clk);
    cmdOut <= {1'b1, w, p, pec, code, d[15:8], d[7:0]};
    @(posedge ref_clk);
    cmdOut.valid <= 1'b0;
  endtask : send
  task automatic restart();
    send(1'b1, 1'b0, 1'b1, `CMD_ON_OFF, 16'h0000);
    repeat (OFF_WAIT) @(posedge ref_clk);
    send(1'b1, 1'b0, 1'b1, `CMD_ON_OFF, 16'h0080);
  endtask : restart
endmodule : host_ctrl_model

//--- testbench/psu_pmbus_command_handler_test.sv
// self-checking bench of the supply command handler
`timescale 1ns/1ps
`include "psu_cmd_defines.svh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin numErrors++; \
  $display("Error t=%0t got %h exp %h", $time, a, e); end end

module psu_pmbus_command_handler_test;
  localparam logic [15:0] IN_ON = 16'hF964;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic controlPort = 1'b0;
  logic acPresent = 1'b1;
  logic vprogEn = 1'b0;
  logic [15:0] vprogLevel = 16'h5800;
  logic [7:0] faultLive = 8'h00;
  psu_cmd_pkg::cmd_t cmdIn;
  psu_cmd_pkg::rsp_t rsp;
  logic mainOn, commFault;
  logic [15:0] voutTarget, ovLimit;
  logic [7:0] status, lock;
  logic [1:0] alertN;
  int numErrors = 0;
  int comparisons = 0;

  always #2.5 ref_clk = ~ref_clk;

  psu_pmbus_command_handler #(.IN_START_LEVEL(IN_ON)) dut (.ref_clk(ref_clk), .arst_n(arst_n),
    .cmdIn(cmdIn), .controlPort(controlPort), .acPresent(acPresent), .vprogEn(vprogEn),
    .vprogLevel(vprogLevel), .faultLive(faultLive), .rsp_ff(rsp), .mainOn_ff(mainOn),
    .voutTarget_ff(voutTarget), .ovLimit_ff(ovLimit), .status_ff(status),
    .commFault_ff(commFault), .alertN_ff(alertN), .lock_ff(lock));
  host_ctrl_model host (.ref_clk(ref_clk), .rsp_ff(rsp), .cmdOut(cmdIn));

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic op(logic w, logic p, logic pec, logic [7:0] code, logic [15:0] d);
    host.send(w, p, pec, code, d);
    repeat (3) @(posedge ref_clk);
    #1;
  endtask : op
  task automatic wr(logic [7:0] code, logic [15:0] d);
    op(1'b1, 1'b0, 1'b1, code, d);
  endtask : wr
  task automatic rd(logic [7:0] code);
    op(1'b0, 1'b0, 1'b1, code, 16'h0000);
  endtask : rd
  // fault flag and port 0 alert; a raised fault is cleared afterwards
  task automatic flt(logic e);
    `CHK({commFault, alertN}, e ? 3'b110 : 3'b011)
    if (e)
      wr(`CMD_CLEAR, 16'h0000);
  endtask : flt
  task automatic pins(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : pins
  task automatic tally_and_finish();
    if (numErrors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    numErrors++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge ref_clk);
    arst_n <= 1'b1;
    pins(1);
    `CHK(mainOn, 1'b1)
    `CHK(lock, 8'h00)
    `CHK(ovLimit, 16'h7800)
    `CHK(voutTarget, 16'h6E00)
    flt(1'b0);
    rd(`CMD_VOUT_FORMAT);
    `CHK({host.lastRsp.bytes, host.lastRsp.data[7:0]}, {4'h1, 3'b000, 5'h17})
    wr(`CMD_VOUT_SET, 16'h7400);
    `CHK(voutTarget, 16'h7400)
    wr(`CMD_VOUT_SET, 16'h7401);
    `CHK(voutTarget, 16'h7400)
    op(1'b1, 1'b1, 1'b1, `CMD_CLEAR, 16'h0000);
    flt(1'b1);
    flt(1'b0);
    op(1'b1, 1'b0, 1'b0, `CMD_VOUT_SET, 16'h6000);
    `CHK(voutTarget, 16'h7400)
    flt(1'b1);
    wr(`CMD_IN_START, 16'h0000);
    flt(1'b1);
    wr(`CMD_ON_OFF, 16'h0001);
    `CHK(mainOn, 1'b1)
    flt(1'b1);
    wr(`CMD_ON_OFF, 16'h0000);
    `CHK(mainOn, 1'b0)
    wr(`CMD_LOCK, 16'h0080);
    `CHK(lock, 8'h80)
    wr(`CMD_VOUT_SET, 16'h5800);
    `CHK(voutTarget, 16'h7400)
    flt(1'b1);
    wr(`CMD_ON_OFF, 16'h0080);
    `CHK(mainOn, 1'b0)
    flt(1'b1);
    rd(`CMD_IN_START);
    `CHK(host.lastRsp.data[15:0], IN_ON)
    wr(`CMD_LOCK, 16'h0040);
    wr(`CMD_ON_OFF, 16'h0080);
    `CHK(mainOn, 1'b1)
    wr(`CMD_VOUT_SET, 16'h5800);
    flt(1'b1);
    wr(`CMD_LOCK, 16'h0000);
    wr(`CMD_ON_OFF, 16'h0001);
    host.restart();
    pins(3);
    flt(1'b0);
    @(posedge ref_clk);
    faultLive <= 8'h01;
    pins(4);
    `CHK(|status, 1'b1)
    wr(`CMD_CLEAR, 16'h0000);
    `CHK(|status, 1'b1)
    @(posedge ref_clk);
    faultLive <= 8'h00;
    pins(4);
    wr(`CMD_CLEAR, 16'h0000);
    `CHK(status, 8'h00)
    wr(`CMD_VOUT_SET, 16'h6400);
    wr(`CMD_STORE_USER, 16'h0021);
    wr(`CMD_VOUT_SET, 16'h6800);
    wr(`CMD_RESTORE_USER, 16'h0021);
    `CHK(voutTarget, 16'h6400)
    wr(`CMD_RESTORE_ONE, 16'h0021);
    `CHK(voutTarget, 16'h6E00)
    wr(`CMD_OVF, 16'h7000);
    `CHK(ovLimit, 16'h7000)
    wr(`CMD_VOUT_SET, 16'h6400);
    wr(`CMD_RESTORE_ALL, 16'h0000);
    `CHK({ovLimit, voutTarget}, {16'h7800, 16'h6E00})
    wr(`CMD_STORE_USER, 16'h0010);
    flt(1'b1);
    wr(`CMD_LOCK, 16'h0080);
    @(posedge ref_clk);
    vprogEn <= 1'b1;
    acPresent <= 1'b0;
    pins(6);
    @(posedge ref_clk);
    acPresent <= 1'b1;
    pins(6);
    `CHK({lock, mainOn, voutTarget}, {8'h00, 1'b1, 16'h5800})
    wr(`CMD_VOUT_SET, 16'h6400);
    @(posedge ref_clk);
    vprogLevel <= 16'h5A00;
    pins(6);
    `CHK(voutTarget, 16'h6400)
    tally_and_finish();
  end
endmodule : psu_pmbus_command_handler_test
